// File: hdl/lcdh_ram.sv
// small ram with registered read port
`timescale 1ns/10ps
module lcdh_ram #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : lcdh_ram

// File: hdl/lcdh_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/10ps
module lcdh_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule : lcdh_sync

// File: hdl/lcdh_top.sv
// instruction decoder and host bus port of the display controller
`timescale 1ns/10ps
`include "lcdh_params.svh"
module lcdh_top #(
    parameter int LONG_CYCLES = (`LCDH_T_LONG_NS + `LCDH_CLK_NS - 1) / `LCDH_CLK_NS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire lcdh_pkg::lcdh_bus_s bus_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic busy_o,
    output logic [6:0] address_pointer_o,
    output logic [6:0] shift_offset_o,
    output lcdh_pkg::lcdh_view_s view_o
);
    import lcdh_pkg::*;

    localparam int DATA_CYCLES = (`LCDH_T_DATA_NS + `LCDH_CLK_NS - 1) / `LCDH_CLK_NS;
    localparam int SHORT_CYCLES = (`LCDH_T_SHORT_NS + `LCDH_CLK_NS - 1) / `LCDH_CLK_NS;
    localparam lcdh_cnt_t CNT_DATA = lcdh_cnt_t'(DATA_CYCLES - 1);
    localparam lcdh_cnt_t CNT_SHORT = lcdh_cnt_t'(SHORT_CYCLES - 1);
    localparam lcdh_cnt_t CNT_LONG = lcdh_cnt_t'(LONG_CYCLES - 1);

    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up);
        step_addr = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    endfunction : step_addr

    // pin synchronisation and strobe edge
    lcdh_bus_s bus_q;
    logic [10:0] bus_raw;
    logic strobe_d;
    assign bus_raw = bus_i;
    lcdh_sync #(.W(11)) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(bus_raw),
        .q_o(bus_q)
    );

    // state
    lcdh_state_e state;
    lcdh_state_e next_state;
    lcdh_cnt_t cnt;
    lcdh_cnt_t next_cnt;
    logic busy;
    logic wide;
    logic inc;
    logic shift_en;
    logic glyph_sel;
    logic nib_phase;
    logic [3:0] nib_hi;
    logic cmd_valid;
    logic cmd_sel;
    logic cmd_rw;
    logic [7:0] cmd_byte;
    logic [6:0] addr;
    logic [6:0] offset;
    logic [6:0] clr_addr;
    logic [7:0] out_reg;
    logic pf_req;
    logic pf_cap;
    lcdh_view_s view;

    // access assembly
    wire fall = strobe_d & ~bus_q.strobe;
    wire acc_done = fall & (wide | nib_phase);
    wire [7:0] full_byte = wide ? bus_q.data : {nib_hi, bus_q.data[7:4]};

    // decode of an accepted access
    // status reads match none of these and leave busy alone
    wire take = cmd_valid & ~busy;
    wire is_instr = take & ~cmd_sel & ~cmd_rw;
    wire is_write = take & cmd_sel & ~cmd_rw;
    wire is_read = take & cmd_sel & cmd_rw;
    wire op_clear = is_instr & (cmd_byte == `LCDH_OP_CLEAR);
    wire op_home = is_instr & (cmd_byte[7:1] == `LCDH_OP_HOME);
    wire op_entry = is_instr & (cmd_byte[7:2] == `LCDH_OP_ENTRY);
    wire op_disp = is_instr & (cmd_byte[7:3] == `LCDH_OP_DISP);
    wire op_shift = is_instr & (cmd_byte[7:4] == `LCDH_OP_SHIFT);
    wire op_func = is_instr & (cmd_byte[7:5] == `LCDH_OP_FUNC);
    wire op_gset = is_instr & (cmd_byte[7:6] == `LCDH_OP_GSET);
    wire op_bset = is_instr & cmd_byte[7];
    wire sh_disp = cmd_byte[`LCDH_BIT_SHIFT_SC];
    wire sh_right = cmd_byte[`LCDH_BIT_SHIFT_RL];
    wire cur_shift = op_shift & ~sh_disp;
    wire write_shift = is_write & ~glyph_sel & shift_en;
    wire op_long = op_clear | op_home;
    wire op_any = is_instr | is_write | is_read;

    // next pointer, shift offset and timing
    wire [6:0] next_addr =
        (op_clear | op_home) ? `LCDH_HOME_ADDR :
        op_gset ? {1'b0, cmd_byte[5:0]} :
        op_bset ? cmd_byte[6:0] :
        cur_shift ? step_addr(addr, sh_right) :
        (is_write | is_read) ? step_addr(addr, inc) :
        addr;
    wire [6:0] next_offset =
        (op_clear | op_home) ? 7'h00 :
        (op_shift & sh_disp) ? step_addr(offset, ~sh_right) :
        write_shift ? step_addr(offset, inc) :
        offset;
    wire [7:0] rd_byte = bus_q.register_select ? out_reg : {busy, addr};
    wire [7:0] drive_byte = wide ? rd_byte :
        (nib_phase ? {rd_byte[3:0], 4'h0} : {rd_byte[7:4], 4'h0});
    wire pf_start = op_gset | op_bset | is_read | (cur_shift & ~glyph_sel);
    wire cb_we = (state == ST_FILL) | (is_write & ~glyph_sel);
    wire gr_we = is_write & glyph_sel;
    wire [6:0] cb_waddr = (state == ST_FILL) ? clr_addr : addr;
    wire [7:0] cb_wdata = (state == ST_FILL) ? `LCDH_SPACE_CODE : cmd_byte;
    wire [7:0] cb_rdata;
    wire [7:0] gr_rdata;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_IDLE: begin
                if (op_any) begin
                    next_state = op_clear ? ST_FILL : ST_EXEC;
                    next_cnt = op_long ? CNT_LONG :
                        (is_instr ? CNT_SHORT : CNT_DATA);
                end
            end
            ST_EXEC: begin
                next_cnt = lcdh_cnt_t'(cnt - 1'b1);
                if (cnt == '0) begin
                    next_state = ST_IDLE;
                    next_cnt = '0;
                end
            end
            ST_FILL: begin
                next_cnt = lcdh_cnt_t'(cnt - 1'b1);
                if (clr_addr == `LCDH_CB_LAST) begin
                    next_state = ST_EXEC;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cnt <= '0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            busy <= (next_state != ST_IDLE);
        end
    end

    // bus capture
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            strobe_d <= 1'b0;
            nib_phase <= 1'b0;
            nib_hi <= 4'h0;
            cmd_valid <= 1'b0;
            cmd_sel <= 1'b0;
            cmd_rw <= 1'b0;
            cmd_byte <= 8'h00;
        end else begin
            strobe_d <= bus_q.strobe;
            cmd_valid <= acc_done;
            if (fall & ~wide) begin
                nib_phase <= ~nib_phase;
                nib_hi <= bus_q.data[7:4];
            end else if (wide) begin
                nib_phase <= 1'b0;
            end
            if (acc_done) begin
                cmd_sel <= bus_q.register_select;
                cmd_rw <= bus_q.rw;
                cmd_byte <= full_byte;
            end
        end
    end

    // mode bits and pointer
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wide <= `LCDH_RST_WIDE;
            inc <= `LCDH_RST_INC;
            shift_en <= `LCDH_RST_OFF;
            glyph_sel <= 1'b0;
            view <= '0;
            addr <= `LCDH_HOME_ADDR;
            offset <= 7'h00;
        end else begin
            addr <= next_addr;
            offset <= next_offset;
            if (op_clear) begin
                inc <= 1'b1;
            end else if (op_entry) begin
                inc <= cmd_byte[`LCDH_BIT_ENTRY_DIR];
                shift_en <= cmd_byte[`LCDH_BIT_ENTRY_WSHIFT];
            end
            if (op_disp) begin
                view.display_on <= cmd_byte[`LCDH_BIT_DISP_D];
                view.cursor_on <= cmd_byte[`LCDH_BIT_DISP_C];
                view.blink_on <= cmd_byte[`LCDH_BIT_DISP_B];
            end
            if (op_func) begin
                wide <= cmd_byte[`LCDH_BIT_FUNC_WIDTH];
                view.two_line <= cmd_byte[`LCDH_BIT_FUNC_N];
                view.tall_font <= cmd_byte[`LCDH_BIT_FUNC_F];
            end
            if (op_gset) begin
                glyph_sel <= 1'b1;
            end else if (op_bset | op_clear | op_home) begin
                glyph_sel <= 1'b0;
            end
        end
    end

    // clear fill and prefetch of the output data register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clr_addr <= 7'h00;
            pf_req <= 1'b0;
            pf_cap <= 1'b0;
            out_reg <= 8'h00;
        end else begin
            clr_addr <= (state == ST_FILL) ? 7'(clr_addr + 7'h01) : 7'h00;
            pf_req <= pf_start;
            pf_cap <= pf_req;
            if (pf_cap) begin
                out_reg <= glyph_sel ? gr_rdata : cb_rdata;
            end
        end
    end

    // character buffer and glyph memories
    lcdh_ram #(.AW(7), .DW(8)) u_char_buf (
        .clk_i(clk_i),
        .we_i(cb_we),
        .waddr_i(cb_waddr),
        .wdata_i(cb_wdata),
        .raddr_i(addr),
        .rdata_o(cb_rdata)
    );

    lcdh_ram #(.AW(6), .DW(8)) u_glyph (
        .clk_i(clk_i),
        .we_i(gr_we),
        .waddr_i(addr[5:0]),
        .wdata_i(cmd_byte),
        .raddr_i(addr[5:0]),
        .rdata_o(gr_rdata)
    );

    // outputs
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_o <= 8'h00;
            data_oe_o <= 1'b0;
            busy_o <= 1'b0;
            address_pointer_o <= 7'h00;
            shift_offset_o <= 7'h00;
            view_o <= '0;
        end else begin
            data_o <= drive_byte;
            data_oe_o <= bus_q.strobe & bus_q.rw;
            busy_o <= busy;
            address_pointer_o <= addr;
            shift_offset_o <= offset;
            view_o <= view;
        end
    end
endmodule : lcdh_top

// File: include/lcdh_params.svh
// constants for the display controller host port
`ifndef LCDH_PARAMS_SVH
`define LCDH_PARAMS_SVH
`define LCDH_CLK_NS 20
`define LCDH_T_DATA_NS 43000
`define LCDH_T_SHORT_NS 39000
`define LCDH_T_LONG_NS 1530000
`define LCDH_SPACE_CODE 8'h20
`define LCDH_HOME_ADDR 7'h00
`define LCDH_CB_LAST 7'h4F
`define LCDH_OP_CLEAR 8'h01
`define LCDH_OP_HOME 7'h01
`define LCDH_OP_ENTRY 6'h01
`define LCDH_OP_DISP 5'h01
`define LCDH_OP_SHIFT 4'h1
`define LCDH_OP_FUNC 3'h1
`define LCDH_OP_GSET 2'h1
`define LCDH_BIT_ENTRY_DIR 1
`define LCDH_BIT_ENTRY_WSHIFT 0
`define LCDH_BIT_DISP_D 2
`define LCDH_BIT_DISP_C 1
`define LCDH_BIT_DISP_B 0
`define LCDH_BIT_SHIFT_SC 3
`define LCDH_BIT_SHIFT_RL 2
`define LCDH_BIT_FUNC_WIDTH 4
`define LCDH_BIT_FUNC_N 3
`define LCDH_BIT_FUNC_F 2
`define LCDH_RST_WIDE 1'b1
`define LCDH_RST_INC 1'b1
`define LCDH_RST_OFF 1'b0
`endif

// File: include/lcdh_pkg.sv
// types for the display controller host port
package lcdh_pkg;
    typedef struct packed {
        logic register_select;
        logic rw;
        logic strobe;
        logic [7:0] data;
    } lcdh_bus_s;
    typedef struct packed {
        logic display_on;
        logic cursor_on;
        logic blink_on;
        logic two_line;
        logic tall_font;
    } lcdh_view_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FILL = 2'b11
    } lcdh_state_e;
    typedef logic [16:0] lcdh_cnt_t;
endpackage : lcdh_pkg

// File: testbench/lcdh_host.sv
// host processor model on the parallel pins
`timescale 1ns/10ps
module lcdh_host (
    input wire logic clk_i,
    input wire logic [7:0] data_i,
    input wire logic busy_i,
    output lcdh_pkg::lcdh_bus_s bus_o
);
    import lcdh_pkg::*;
    logic [7:0] last_w;
    initial begin
        last_w = 8'h00;
        bus_o = '0;
    end
    // one strobe pulse, fields held around the fall
    task automatic xfer(input logic sel, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk_i);
        bus_o.register_select = sel;
        bus_o.rw = rw;
        bus_o.data = rw ? ~last_w : d;
        bus_o.strobe = 1'b1;
        repeat (5) @(negedge clk_i);
        q = data_i;
        bus_o.strobe = 1'b0;
        repeat (4) @(negedge clk_i);
        last_w = rw ? last_w : d;
        bus_o.data = ~last_w;
    endtask : xfer
    // busy low, then a margin before the next fall
    task automatic wait_idle();
        repeat (8) @(negedge clk_i);
        while (busy_i) begin
            @(negedge clk_i);
        end
        repeat (2) @(negedge clk_i);
    endtask : wait_idle
endmodule : lcdh_host

// File: testbench/lcdh_props.sv
// pin assertions for the display controller host port
`timescale 1ns/10ps
module lcdh_props #(
    parameter int LONG_CYCLES = 200
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire lcdh_pkg::lcdh_bus_s bus_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic busy_o,
    input wire logic [6:0] address_pointer_o,
    input wire logic [6:0] shift_offset_o,
    input wire lcdh_pkg::lcdh_view_s view_o
);
    import lcdh_pkg::*;
    logic [16:0] busy_len;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_len <= 17'h0;
        end else begin
            busy_len <= busy_o ? busy_len + 17'h1 : 17'h0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_oe_on_read: assert property (
        (bus_i.strobe && bus_i.rw)[*4] |-> data_oe_o) else $error("read not driven");
    a_oe_off_idle: assert property (
        (!bus_i.strobe)[*4] |-> !data_oe_o) else $error("driven when idle");
    a_oe_read_only: assert property (
        data_oe_o |-> $past(bus_i.rw, 3)) else $error("driven on write");
    a_status_word: assert property (
        (bus_i.strobe && bus_i.rw && !bus_i.register_select && $stable(busy_o)
        && $stable(address_pointer_o))[*5] |-> data_o == {busy_o, address_pointer_o})
        else $error("bad status word");
    a_busy_span: assert property (
        $fell(busy_o) |-> busy_len inside {[1948:1953], [2148:2153],
        [LONG_CYCLES-2:LONG_CYCLES+2]}) else $error("bad busy length");
    a_busy_freeze: assert property (
        busy_o && $past(busy_o) |-> $stable(view_o) && $stable(shift_offset_o))
        else $error("state moved while busy");
    a_idle_steady: assert property (
        (!bus_i.strobe && !busy_o)[*8] |=> $stable(address_pointer_o) && $stable(view_o))
        else $error("state moved when idle");
    a_reset_clear: assert property (
        $rose(rstn_i) |-> !busy_o && !data_oe_o && address_pointer_o == 7'h00)
        else $error("not cleared by reset");
endmodule : lcdh_props

// File: testbench/lcdh_top_tb.sv
// self-checking bench for the display controller host port
`timescale 1ns/10ps
module lcdh_top_tb;
    import lcdh_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    lcdh_bus_s hbus;
    lcdh_bus_s dbus;
    logic [7:0] data_o;
    logic data_oe_o;
    logic busy_o;
    logic [6:0] ptr;
    logic [6:0] shift;
    lcdh_view_s view;
    int bad_count = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h0000C733;
    logic [7:0] r;
    logic [6:0] a;
    logic [2:0] dc [4] = '{3'h5, 3'h2, 3'h7, 3'h0};
    always #10 clk_i = ~clk_i;
    assign dbus = {hbus.register_select, hbus.rw, hbus.strobe, data_oe_o ? data_o : hbus.data};
    lcdh_top #(.LONG_CYCLES(200)) uut (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(dbus),
        .data_o(data_o), .data_oe_o(data_oe_o), .busy_o(busy_o), .address_pointer_o(ptr),
        .shift_offset_o(shift), .view_o(view));
    lcdh_host host (.clk_i(clk_i), .data_i(dbus.data), .busy_i(busy_o), .bus_o(hbus));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [7:0] stat(input logic [6:0] p, input int n);
        return {1'b0, p + 7'(n)};
    endfunction : stat
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic sel, input logic [7:0] d);
        host.xfer(sel, 1'b0, d, r);
        host.wait_idle();
    endtask : wr
    task automatic rd(input logic sel, input logic [7:0] e);
        host.xfer(sel, 1'b1, 8'hFF, r);
        check(r, e);
        if (sel) begin
            host.wait_idle();
        end
    endtask : rd
    task automatic xb(input logic [7:0] d, input logic e);
        host.xfer(1'b0, 1'b0, d, r);
        repeat (4) @(negedge clk_i);
        check({7'h00, busy_o}, {7'h00, e});
    endtask : xb
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    initial begin
        #(90000 * 20);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        rd(1'b0, 8'h00);
        check({3'h0, view}, 8'h00);
        xb(8'h01, 1'b1);
        host.wait_idle();
        rd(1'b0, 8'h00);
        wr(1'b0, 8'hCF);
        rd(1'b1, 8'h20);
        rd(1'b0, 8'h50);
        $display("clear test done");
        seed = xs(seed);
        a = {1'b0, seed[5:0]};
        wr(1'b0, {1'b1, a});
        wr(1'b1, seed[15:8]);
        wr(1'b1, seed[23:16]);
        rd(1'b0, stat(a, 2));
        wr(1'b0, {1'b1, a + 7'h02});
        wr(1'b0, 8'h10);
        rd(1'b1, seed[23:16]);
        rd(1'b0, stat(a, 2));
        wr(1'b0, 8'h04);
        wr(1'b0, {1'b1, a + 7'h01});
        rd(1'b1, seed[23:16]);
        rd(1'b1, seed[15:8]);
        rd(1'b0, stat(a, -1));
        wr(1'b0, 8'h06);
        wr(1'b0, {1'b1, a});
        wr(1'b1, seed[23:16]);
        rd(1'b1, seed[15:8]);
        rd(1'b0, stat(a, 2));
        wr(1'b0, 8'h18);
        check({1'b0, shift}, 8'h01);
        rd(1'b0, stat(a, 2));
        wr(1'b0, 8'h07);
        wr(1'b1, seed[7:0]);
        check({1'b0, shift}, 8'h02);
        wr(1'b0, 8'h14);
        wr(1'b0, 8'h1C);
        check({1'b0, shift}, 8'h01);
        check({1'b0, ptr}, stat(a, 4));
        wr(1'b0, 8'h02);
        check({1'b0, shift}, 8'h00);
        rd(1'b0, 8'h00);
        $display("ram test done");
        for (int i = 0; i < 4; i++) begin
            wr(1'b0, {5'h01, dc[i]});
            check({5'h00, view[4:2]}, {5'h00, dc[i]});
        end
        for (int i = 1; i < 3; i++) begin
            wr(1'b0, {4'h3, i[1:0], 2'h3});
            check({6'h00, view[1:0]}, {6'h00, i[1:0]});
        end
        seed = xs(seed);
        wr(1'b0, {2'h1, seed[5:0]});
        wr(1'b1, seed[15:8]);
        wr(1'b0, {2'h1, seed[5:0]});
        rd(1'b1, seed[15:8]);
        rd(1'b0, stat({1'b0, seed[5:0]}, 1));
        host.xfer(1'b0, 1'b0, 8'h0F, r);
        host.xfer(1'b0, 1'b0, 8'h08, r);
        host.wait_idle();
        check({5'h00, view[4:2]}, 8'h07);
        $display("mode test done");
        wr(1'b0, 8'h20);
        xb(8'h30, 1'b0);
        xb(8'h80, 1'b1);
        host.wait_idle();
        check({6'h00, view[1:0]}, 8'h02);
        $display("width test done");
        final_report();
    end
endmodule : lcdh_top_tb
bind lcdh_top lcdh_props #(.LONG_CYCLES(LONG_CYCLES)) props (.clk_i(clk_i),
    .rstn_i(rstn_i), .bus_i(bus_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .busy_o(busy_o), .address_pointer_o(address_pointer_o),
    .shift_offset_o(shift_offset_o), .view_o(view_o));
